//--- inc/flash_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flash_bus_if;
  logic req;
  logic [11:0] addr;
  logic [15:0] data;
  logic rd;
  logic done;
  logic [15:0] rdata;
  modport master (output req, output addr, output data, output rd, input done, input rdata);
  modport cycler (input req, input addr, input data, input rd, output done, output rdata);
endinterface : flash_bus_if
`default_nettype wire

//--- inc/flash_seq_map.svh
// Operation
// RULE1: Suspend 51h/B0h, resume 50h/30h accepted
// RULE2: Device halts program within suspend latency
// RULE3: Program suspended: only reads, status, resume
// RULE4: Resume restarts program; repeats ignored
// RULE5: Host waits resume gap before next suspend
// RULE6: No suspend with overlay entered
// RULE7: Chip erase leaves all words FFFFh
// RULE8: Chip erase is six write cycles
// RULE9: Chip erase: only status read honoured
// RULE10: Hardware reset ends erase, recovery wait
// RULE11: Chip erase skips protected sectors
// RULE12: Sector erase six cycles with sector address
// RULE13: Sector erase: only status and suspend
// RULE14: Erase suspend ignored during chip erase
// RULE15: Reads inside suspended sector invalid
// RULE16: Program from erase suspend returns there
// RULE17: Program failure needs clear, then resume
// RULE18: Erase suspend: limited command set
// RULE19: Erase resume restarts; repeat ignored
// RULE20: Blank check 33h at 555 from standby; code writes it at sector_i OR 555h
// RULE21: Status bit 7 ready, bit 5 not blank
// RULE22: Blank check stops at first dirty bit
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
`define UNLOCK1_ADDR 12'h555
`define UNLOCK2_ADDR 12'h2AA
`define UNLOCK1_DATA 16'h00AA
`define UNLOCK2_DATA 16'h0055
`define SETUP_ERASE_DATA 16'h0080
`define CHIP_ERASE_DATA 16'h0010
`define SECTOR_ERASE_DATA 16'h0030
`define PGM_SUSPEND_DATA 16'h0051
`define PGM_RESUME_DATA 16'h0050
`define ERS_SUSPEND_DATA 16'h00B0
`define ERS_RESUME_DATA 16'h0030
`define BLANK_CHECK_DATA 16'h0033
`define STATUS_READ_DATA 16'h0070
`define CLEAR_STATUS_DATA 16'h0071
`define STATUS_READY_BIT 7
`define STATUS_ERASE_BIT 5
`define STATUS_PGM_BIT 4
`define CLK_PERIOD_NS 4
`define T_WRITE_NS 40
`define WRITE_CYCLES ((`T_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_SUSPEND_LATENCY_NS 40000
`define T_RESUME_GAP_NS 100000
`define T_RESET_RECOVERY_NS 400
`define RESET_CYCLES ((`T_RESET_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASED_WORD 16'hFFFF
`define CNT_W 16
`endif

//--- inc/flash_seq_pkg.sv
package flash_seq_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_CHIP_ERASE = 4'h1,
    OP_SECTOR_ERASE = 4'h2,
    OP_ERASE_SUSPEND = 4'h3,
    OP_ERASE_RESUME = 4'h4,
    OP_PGM_SUSPEND = 4'h5,
    OP_PGM_RESUME = 4'h6,
    OP_BLANK_CHECK = 4'h7,
    OP_CLEAR_STATUS = 4'h8,
    OP_HW_RESET = 4'h9
  } op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ERASING = 3'b001,
    ST_ERS_SUSP = 3'b011,
    ST_PROGRAMMING = 3'b010,
    ST_PGM_SUSP = 3'b110,
    ST_BLANK = 3'b111,
    ST_RECOVER = 3'b101
  } mode_t;
endpackage : flash_seq_pkg

//--- rtl/flash_bus_cycler.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_map.svh"
module flash_bus_cycler
  import flash_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  flash_bus_if.cycler bus,
  // Pins
  output logic [11:0] fl_addr_o,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe_o,
  output logic fl_we_n_o,
  output logic fl_oe_n_o,
  input wire logic [15:0] fl_dq_i
);
  typedef struct packed {
    logic busy;
    logic rd;
    logic [`CNT_W-1:0] cnt;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
  } cyc_t;
  cyc_t s_reg, s_next;
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.dq_s1 = fl_dq_i;
    s_next.dq_s2 = s_reg.dq_s1;
    if (!s_reg.busy && bus.req)
    begin
      s_next.busy = 1'b1;
      s_next.rd = bus.rd;
      s_next.addr = bus.addr;
      s_next.wdata = bus.data;
      // Extra cycles cover the two-stage input sampler
      s_next.cnt = `CNT_W'(`WRITE_CYCLES + 2);
    end
    else if (s_reg.busy)
    begin
      if (s_reg.cnt == '0)
      begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
        s_next.rdata = s_reg.dq_s2;
      end
      else
        s_next.cnt = s_reg.cnt - `CNT_W'(1);
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fl_we_n_o <= 1'b1;
      fl_oe_n_o <= 1'b1;
      fl_dq_oe_o <= 1'b0;
      fl_addr_o <= '0;
      fl_dq_o <= '0;
    end
    else
    begin
      fl_we_n_o <= !(s_next.busy && !s_next.rd && s_next.cnt > `CNT_W'(2));
      fl_oe_n_o <= !(s_next.busy && s_next.rd);
      fl_dq_oe_o <= s_next.busy && !s_next.rd;
      fl_addr_o <= s_next.addr;
      fl_dq_o <= s_next.wdata;
    end
  end
  assign bus.done = s_reg.done;
  assign bus.rdata = s_reg.rdata;
endmodule : flash_bus_cycler
`default_nettype wire

//--- rtl/flash_seq_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_map.svh"
module flash_seq_host
  import flash_seq_pkg::*;
#(
  parameter int RESUME_GAP_CYCLES = `T_RESUME_GAP_NS / `CLK_PERIOD_NS
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Command port
  input wire logic op_valid_i,
  input wire op_t op_i,
  input wire logic [11:0] sector_i,
  output logic op_ready_o,
  output logic op_done_o,
  output logic op_refused_o,
  // Status
  output logic busy_o,
  output logic not_blank_o,
  output logic erase_fail_o,
  output logic [2:0] mode_o,
  // Flash pins
  output logic [11:0] fl_addr_o,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe_o,
  output logic fl_we_n_o,
  output logic fl_oe_n_o,
  output logic fl_reset_n_o,
  input wire logic [15:0] fl_dq_i,
  input wire logic overlay_active_i
);
  flash_bus_if bus ();
  flash_bus_cycler u_cyc (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .bus(bus),
    .fl_addr_o(fl_addr_o),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe_o(fl_dq_oe_o),
    .fl_we_n_o(fl_we_n_o),
    .fl_oe_n_o(fl_oe_n_o),
    .fl_dq_i(fl_dq_i)
  );
  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_WRITE = 3'b001,
    P_WAIT = 3'b011,
    P_POLL = 3'b010,
    P_POLLW = 3'b110,
    P_RST = 3'b111
  } phase_t;
  typedef struct packed {
    phase_t phase;
    mode_t mode;
    mode_t after;
    logic [2:0] step;
    logic [2:0] nsteps;
    logic [11:0] sector;
    logic [15:0] cmd;
    logic [`CNT_W-1:0] tmr;
    logic [31:0] gap;
    logic req;
    logic rd;
    logic done;
    logic refused;
    logic not_blank;
    logic fail;
    logic ovl_s1;
    logic ovl_s2;
    logic rst_n;
    logic chip;
  } host_t;
  host_t s_reg, s_next;
  // ----------------------------------------
  // Acceptance per mode
  // ----------------------------------------
  function automatic logic allowed(input mode_t m, input op_t o, input logic ovl,
                                   input logic gap_ok, input logic chip);
    logic r;
    r = 1'b0;
    unique case (m)
      ST_IDLE: r = (o == OP_CHIP_ERASE) || (o == OP_SECTOR_ERASE)
                   || (o == OP_BLANK_CHECK) || (o == OP_CLEAR_STATUS); // RULE20
      ST_ERASING: r = (o == OP_ERASE_SUSPEND) && !ovl && !chip; // RULE13 RULE14 RULE19
      ST_ERS_SUSP: r = ((o == OP_ERASE_RESUME) && !ovl) || (o == OP_CLEAR_STATUS); // RULE18 RULE17
      ST_PROGRAMMING: r = (o == OP_PGM_SUSPEND) && !ovl && gap_ok; // RULE5 RULE6
      ST_PGM_SUSP: r = (o == OP_PGM_RESUME) && !ovl; // RULE3 RULE4
      ST_BLANK: r = 1'b0; // RULE20
      ST_RECOVER: r = 1'b0;
      default: r = 1'b0;
    endcase
    return r || (o == OP_HW_RESET); // RULE10
  endfunction : allowed
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.refused = 1'b0;
    s_next.ovl_s1 = overlay_active_i;
    s_next.ovl_s2 = s_reg.ovl_s1;
    if (s_reg.gap != '0)
      s_next.gap = s_reg.gap - 32'd1;
    unique case (s_reg.phase)
      P_IDLE, P_POLL:
      begin
        s_next.rst_n = 1'b1;
        if (op_valid_i)
        begin
          if (!allowed(s_reg.mode, op_i, s_reg.ovl_s2, s_reg.gap == '0, s_reg.chip))
            s_next.refused = 1'b1;
          else
          begin
            s_next.phase = P_WRITE;
            s_next.step = 3'd0;
            s_next.nsteps = 3'd1;
            s_next.sector = '0;
            s_next.after = s_reg.mode; // RULE16
            unique case (op_i)
              OP_CHIP_ERASE:
              begin
                s_next.nsteps = 3'd6; // RULE8 RULE7 RULE11
                s_next.cmd = `CHIP_ERASE_DATA;
                s_next.after = ST_ERASING; // RULE9
                s_next.not_blank = 1'b0;
                s_next.chip = 1'b1;
              end
              OP_SECTOR_ERASE:
              begin
                s_next.nsteps = 3'd6; // RULE12
                s_next.cmd = `SECTOR_ERASE_DATA;
                s_next.chip = 1'b0;
                s_next.sector = sector_i;
                s_next.after = ST_ERASING;
              end
              OP_ERASE_SUSPEND:
              begin
                s_next.cmd = `ERS_SUSPEND_DATA;
                s_next.after = ST_ERS_SUSP; // RULE15
              end
              OP_ERASE_RESUME:
              begin
                s_next.cmd = `ERS_RESUME_DATA;
                s_next.after = ST_ERASING;
              end
              OP_PGM_SUSPEND:
              begin
                s_next.cmd = `PGM_SUSPEND_DATA; // RULE1 RULE2
                s_next.after = ST_PGM_SUSP;
              end
              OP_PGM_RESUME:
              begin
                s_next.cmd = `PGM_RESUME_DATA; // RULE1
                s_next.after = ST_PROGRAMMING;
                s_next.gap = 32'(RESUME_GAP_CYCLES); // RULE5
              end
              OP_BLANK_CHECK:
              begin
                s_next.cmd = `BLANK_CHECK_DATA;
                s_next.sector = sector_i;
                s_next.after = ST_BLANK;
              end
              OP_CLEAR_STATUS:
              begin
                s_next.cmd = `CLEAR_STATUS_DATA; // RULE17
                s_next.fail = 1'b0;
              end
              OP_HW_RESET:
              begin
                s_next.phase = P_RST;
                s_next.rst_n = 1'b0;
                s_next.tmr = `CNT_W'(`RESET_CYCLES); // RULE10
              end
              default: s_next.cmd = `STATUS_READ_DATA;
            endcase
            s_next.mode = (op_i == OP_HW_RESET) ? ST_RECOVER : s_reg.mode;
          end
        end
        else if (s_reg.phase == P_POLL)
        begin
          s_next.req = 1'b1;
          s_next.rd = 1'b1;
          s_next.phase = P_POLLW;
        end
      end
      P_WRITE:
      begin
        s_next.req = 1'b1;
        s_next.rd = 1'b0;
        s_next.phase = P_WAIT;
      end
      P_WAIT:
      begin
        s_next.req = 1'b0;
        if (bus.done)
        begin
          if (s_reg.step + 3'd1 < s_reg.nsteps)
          begin
            s_next.step = s_reg.step + 3'd1;
            s_next.phase = P_WRITE;
          end
          else
          begin
            s_next.mode = s_reg.after;
            s_next.done = 1'b1;
            s_next.phase = (s_reg.after == ST_ERASING || s_reg.after == ST_BLANK
                            || s_reg.after == ST_PROGRAMMING) ? P_POLL : P_IDLE;
          end
        end
      end
      P_POLLW:
      begin
        s_next.req = 1'b0;
        if (bus.done)
        begin
          if (bus.rdata[`STATUS_READY_BIT])
          begin
            s_next.phase = P_IDLE;
            s_next.mode = ST_IDLE; // RULE22
            if (s_reg.mode == ST_BLANK)
              s_next.not_blank = bus.rdata[`STATUS_ERASE_BIT]; // RULE21
            else
              s_next.fail = bus.rdata[`STATUS_ERASE_BIT] | bus.rdata[`STATUS_PGM_BIT];
          end
          else
            s_next.phase = P_POLL;
        end
      end
      P_RST:
      begin
        if (s_reg.tmr == '0)
        begin
          s_next.rst_n = 1'b1;
          s_next.mode = ST_IDLE;
          s_next.phase = P_IDLE;
          s_next.done = 1'b1;
        end
        else
          s_next.tmr = s_reg.tmr - `CNT_W'(1);
      end
      default: s_next.phase = P_IDLE;
    endcase
  end
  // ----------------------------------------
  // Unlock cycle addressing
  // ----------------------------------------
  always_comb
  begin
    bus.req = s_reg.req;
    bus.rd = s_reg.rd;
    bus.addr = s_reg.sector;
    bus.data = s_reg.cmd;
    if (s_reg.rd)
      bus.data = `STATUS_READ_DATA;
    else if (s_reg.nsteps == 3'd6)
    begin
      // Six-cycle erase: AA, 55, 80, AA, 55, command
      unique case (s_reg.step)
        3'd0, 3'd3: begin bus.addr = `UNLOCK1_ADDR; bus.data = `UNLOCK1_DATA; end
        3'd1, 3'd4: begin bus.addr = `UNLOCK2_ADDR; bus.data = `UNLOCK2_DATA; end
        3'd2: begin bus.addr = `UNLOCK1_ADDR; bus.data = `SETUP_ERASE_DATA; end
        default: bus.data = s_reg.cmd;
      endcase
    end
    else if (s_reg.cmd == `BLANK_CHECK_DATA)
      bus.addr = s_reg.sector | `UNLOCK1_ADDR; // RULE20
  end
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_reg <= '0;
      s_reg.rst_n <= 1'b1;
    end
    else
      s_reg <= s_next;
  end
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      op_ready_o <= 1'b0;
      op_done_o <= 1'b0;
      op_refused_o <= 1'b0;
      busy_o <= 1'b0;
      not_blank_o <= 1'b0;
      erase_fail_o <= 1'b0;
      mode_o <= '0;
      fl_reset_n_o <= 1'b1;
    end
    else
    begin
      op_ready_o <= (s_next.phase == P_IDLE) || (s_next.phase == P_POLL);
      op_done_o <= s_next.done;
      op_refused_o <= s_next.refused;
      busy_o <= s_next.mode != ST_IDLE;
      not_blank_o <= s_next.not_blank;
      erase_fail_o <= s_next.fail;
      mode_o <= s_next.mode;
      fl_reset_n_o <= s_next.rst_n;
    end
  end
endmodule : flash_seq_host
`default_nettype wire

//--- tb/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
(
  // Host pins
  input wire logic [11:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic reset_n_i,
  // Scenario control and data to host
  input wire logic dirty_i,
  output logic [15:0] dq_o
);
  typedef enum logic [2:0] {IDLE_S, ERASE_S, CHIP_S, SUSP_S, BLANK_S} dev_t;
  dev_t st = IDLE_S;
  logic [79:0] hist = 80'h0;
  logic [15:0] last = 16'h0000;
  logic [11:0] erase_addr = 12'h000;
  logic fail = 1'b0;
  int left = 0;
  logic [15:0] stat;
  logic susp_w;
  logic chip_w;
  assign susp_w = (st == SUSP_S);
  assign chip_w = (st == CHIP_S);
  // ------
  // Status only; array data is not modelled
  // ------
  assign stat = {8'h00, st inside {IDLE_S, SUSP_S}, 1'b0, fail, 5'h00};
  assign dq_o = oe_n_i ? ~last : stat;
  always @(posedge oe_n_i) last = stat;
  // Sampled 1 ns late so the host's data has settled
  always @(negedge we_n_i)
  begin
    #1;
    if (st == ERASE_S && dq_i inside {16'h00B0, 16'h0051})
      st = SUSP_S;
    else if (st == SUSP_S && dq_i inside {16'h0030, 16'h0050})
      st = ERASE_S;
    else if (st == IDLE_S && dq_i == 16'h0033 && addr_i == 12'h555)
    begin
      st = BLANK_S;
      left = dirty_i ? 3 : 20;
    end
    else if (st == IDLE_S && hist == 80'h00AA_0055_0080_00AA_0055 && dq_i inside {16'h0010,
      16'h0030})
    begin
      st = (dq_i == 16'h0010) ? CHIP_S : ERASE_S;
      erase_addr = addr_i;
      left = 20;
    end
    hist = {hist[63:0], dq_i};
  end
  always #100
    if (left > 0 && st != SUSP_S)
    begin
      left--;
      if (left == 0)
      begin
        fail = (st == BLANK_S) && dirty_i;
        st = IDLE_S;
      end
    end
  always @(negedge reset_n_i)
  begin
    st = IDLE_S;
    left = 0;
  end
endmodule : flash_dev_model
`default_nettype wire

//--- tb/flash_seq_host_checker.sv
`timescale 1ns/1ps
`default_nettype none
module flash_seq_host_checker
  import flash_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Command port
  input wire logic op_valid_i,
  input wire logic op_ready_o,
  input wire logic op_done_o,
  input wire logic op_refused_o,
  // Status and pins
  input wire logic busy_o,
  input wire logic [2:0] mode_o,
  input wire logic fl_dq_oe_o,
  input wire logic fl_we_n_o,
  input wire logic fl_oe_n_o
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_blank_refuse;
    mode_o == ST_BLANK && op_valid_i && op_ready_o |=> op_refused_o;
  endproperty
  a_blank_refuse: assert property (p_blank_refuse) else $error("blank op taken");
  property p_blank_entry;
    mode_o == ST_BLANK && $past(mode_o) != ST_BLANK |-> $past(mode_o) == ST_IDLE;
  endproperty
  a_blank_entry: assert property (p_blank_entry) else $error("blank not from idle");
  property p_blank_exit;
    $past(mode_o) == ST_BLANK && mode_o != ST_BLANK |-> mode_o inside {ST_IDLE, ST_RECOVER};
  endproperty
  a_blank_exit: assert property (p_blank_exit) else $error("blank exit wrong");
  property p_susp_entry;
    mode_o == ST_ERS_SUSP && $past(mode_o) != ST_ERS_SUSP
      |-> $past(mode_o) inside {ST_ERASING, ST_PROGRAMMING};
  endproperty
  a_susp_entry: assert property (p_susp_entry) else $error("suspend from bad mode");
  property p_busy_mode;
    busy_o == (mode_o != ST_IDLE);
  endproperty
  a_busy_mode: assert property (p_busy_mode) else $error("busy disagrees");
  property p_strobe_excl;
    !(!fl_we_n_o && !fl_oe_n_o);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes low");
  property p_read_release;
    !fl_oe_n_o |-> !fl_dq_oe_o;
  endproperty
  a_read_release: assert property (p_read_release) else $error("drive during read");
  property p_answer_excl;
    op_refused_o |-> !op_done_o ##1 !op_refused_o;
  endproperty
  a_answer_excl: assert property (p_answer_excl) else $error("answer clash");
endmodule : flash_seq_host_checker
bind flash_seq_host flash_seq_host_checker chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .op_valid_i(op_valid_i), .op_ready_o(op_ready_o), .op_done_o(op_done_o),
  .op_refused_o(op_refused_o), .busy_o(busy_o), .mode_o(mode_o), .fl_dq_oe_o(fl_dq_oe_o),
  .fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o));
`default_nettype wire

//--- tb/tb_flash_seq_host.sv
`timescale 1ns/1ps
`default_nettype none
module tb_flash_seq_host import flash_seq_pkg::*;;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic op_valid_i = 1'b0;
  op_t op_i = OP_NONE;
  logic [11:0] sector_i = 12'h000;
  logic overlay_active_i = 1'b0;
  logic dirty = 1'b0;
  logic saw_reset = 1'b0;
  logic op_ready_o, op_done_o, op_refused_o, busy_o, not_blank_o, erase_fail_o;
  logic [2:0] mode_o;
  logic [11:0] fl_addr_o;
  logic [15:0] fl_dq_o, dev_dq, dq_w;
  logic fl_dq_oe_o, fl_we_n_o, fl_oe_n_o, fl_reset_n_o;
  int bad_count = 0;
  int total_checks = 0;
  assign dq_w = fl_dq_oe_o ? fl_dq_o : dev_dq;
  flash_seq_host #(.RESUME_GAP_CYCLES(8)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .sector_i(sector_i), .op_ready_o(op_ready_o),
    .op_done_o(op_done_o), .op_refused_o(op_refused_o), .busy_o(busy_o),
    .not_blank_o(not_blank_o), .erase_fail_o(erase_fail_o), .mode_o(mode_o),
    .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o), .fl_we_n_o(fl_we_n_o),
    .fl_oe_n_o(fl_oe_n_o), .fl_reset_n_o(fl_reset_n_o), .fl_dq_i(dq_w),
    .overlay_active_i(overlay_active_i));
  flash_dev_model dev (.addr_i(fl_addr_o), .dq_i(dq_w), .we_n_i(fl_we_n_o),
    .oe_n_i(fl_oe_n_o), .reset_n_i(fl_reset_n_o), .dirty_i(dirty), .dq_o(dev_dq));
  initial forever #2 clk_i = ~clk_i;
  always @(negedge fl_reset_n_o) saw_reset = 1'b1;
  // ------
  // Helpers
  // ------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic wait_lvl(ref logic s, input logic lvl);
    int n = 0;
    while (s !== lvl && n < 20000)
    begin
      @(negedge clk_i);
      n++;
    end
    if (s !== lvl)
    begin
      check(1'b0, "wait ran out");
      finish_test();
    end
  endtask : wait_lvl
  // Valid stands until an edge that sees ready, and drops at that edge
  task automatic issue(input op_t op, input logic [11:0] sec, input logic exp_done);
    int n = 0;
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_i <= op;
    sector_i <= sec;
    @(negedge clk_i);
    wait_lvl(op_ready_o, 1'b1);
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    while (op_done_o !== 1'b1 && op_refused_o !== 1'b1 && n < 20000)
    begin
      @(negedge clk_i);
      n++;
    end
    check(op_done_o === exp_done && op_refused_o === !exp_done, op.name());
    if (n >= 20000)
      finish_test();
  endtask : issue
  // ------
  // Scenarios
  // ------
  task automatic t_sector;
    issue(OP_SECTOR_ERASE, 12'h3A5, 1'b1);
    check(dev.erase_addr === 12'h3A5 && mode_o === ST_ERASING, "erase start");
    issue(OP_BLANK_CHECK, 12'h3A5, 1'b0);
    wait_lvl(busy_o, 1'b0);
    check(not_blank_o === 1'b0 && mode_o === ST_IDLE, "erase end");
    check(erase_fail_o === 1'b0, "erase fail flag");
    $display("sector erase test done");
  endtask : t_sector
  task automatic t_suspend;
    issue(OP_SECTOR_ERASE, 12'h041, 1'b1);
    issue(OP_ERASE_SUSPEND, 12'h041, 1'b1);
    check(mode_o === ST_ERS_SUSP && dev.susp_w === 1'b1, "suspended");
    issue(OP_ERASE_RESUME, 12'h041, 1'b1);
    check(mode_o === ST_ERASING, "resumed");
    issue(OP_ERASE_RESUME, 12'h041, 1'b0);
    wait_lvl(busy_o, 1'b0);
    $display("suspend test done");
  endtask : t_suspend
  task automatic t_chip;
    issue(OP_CHIP_ERASE, 12'h000, 1'b1);
    check(dev.chip_w === 1'b1, "chip start");
    issue(OP_ERASE_SUSPEND, 12'h000, 1'b0);
    wait_lvl(busy_o, 1'b0);
    issue(OP_PGM_SUSPEND, 12'h000, 1'b0);
    $display("chip erase test done");
  endtask : t_chip
  task automatic t_blank(input logic v);
    dirty <= v;
    issue(OP_BLANK_CHECK, 12'h010, 1'b1);
    if (v == 1'b0)
    begin
      check(mode_o === ST_BLANK, "blank mode");
      issue(OP_CLEAR_STATUS, 12'h010, 1'b0);
    end
    wait_lvl(busy_o, 1'b0);
    check(not_blank_o === v, "blank result");
    $display("blank check test done");
  endtask : t_blank
  task automatic t_reset;
    issue(OP_SECTOR_ERASE, 12'h222, 1'b1);
    issue(OP_HW_RESET, 12'h000, 1'b1);
    check(saw_reset === 1'b1 && dev.left == 0 && busy_o === 1'b0, "reset abort");
    $display("reset test done");
  endtask : t_reset
  task automatic t_overlay;
    issue(OP_SECTOR_ERASE, 12'h155, 1'b1);
    @(posedge clk_i);
    overlay_active_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    issue(OP_ERASE_SUSPEND, 12'h155, 1'b0);
    @(posedge clk_i);
    overlay_active_i <= 1'b0;
    wait_lvl(busy_o, 1'b0);
    $display("overlay test done");
  endtask : t_overlay
  initial
  begin
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(negedge clk_i);
    t_sector();
    t_suspend();
    t_chip();
    t_blank(1'b0);
    t_blank(1'b1);
    t_reset();
    t_overlay();
    finish_test();
  end
endmodule : tb_flash_seq_host
`default_nettype wire
